// ---- rtl/timer16_byte_access_port.sv ----
// byte-wide access port, counter landmarks and capture path of a 16-bit timer
//
// Behaviour
// R01: each 16-bit register is reached as two separate byte accesses
// R02: one shared high-byte latch serves counter, both compares and capture
// R03: low-byte write loads latch and written byte together in one cycle
// R04: counter and capture low-byte reads copy the register high byte into the latch
// R05: compare high-byte reads return the register directly, latch untouched
// R06: software writes the high byte first, then the low byte
// R07: software reads the low byte first, then the high byte
// R08: software masks interrupts around its two-byte sequence
// R09: latch keeps its value after a low-byte write
// R10: bottom flag whenever the counter equals zero
// R11: max flag whenever the counter holds all ones
// R12: mode picks top from fixed values, compare a, or capture
// R13: compare a as pwm top is double buffered and gives no pwm
// R14: qualifying edge on pin or comparator copies counter into capture; the code skips the copy in modes using capture as top
// R15: counter high-byte location accesses the shared latch
// R16: enabled filter needs four equal samples before its output moves
// R17: capture accepts writes only in modes using it as top
// R18: a write to the counter beats clear and count in that cycle
// R19: shared latch clears to zero at reset
`timescale 1ns/1ps

module timer16_byte_access_port
    import timer16_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET_N,
    // processor byte bus
    input  wire logic [2:0]  BUS_ADDR,
    input  wire logic        BUS_WRITE,
    input  wire logic        BUS_READ,
    input  wire logic [7:0]  BUS_WDATA,
    output logic      [7:0]  BUS_RDATA,
    // counting control from the counting logic
    input  wire logic [3:0]  WAVEFORM_MODE_BITS,
    input  wire logic        COUNT_STEP,
    input  wire logic        COUNT_DOWN,
    input  wire logic        COUNT_CLEAR,
    // capture control and sources
    input  wire logic        CAPTURE_FILTER_ENABLE,
    input  wire logic        CAPTURE_FROM_COMPARATOR,
    input  wire logic        CAPTURE_RISING_EDGE,
    input  wire logic        CAPTURE_INPUT_PIN,
    input  wire logic        COMPARATOR_OUTPUT,
    // register contents and counter landmarks
    output logic      [15:0] TIMER_COUNT,
    output logic      [15:0] COMPARE_VALUE_A,
    output logic      [15:0] COMPARE_VALUE_B,
    output logic      [15:0] CAPTURE_VALUE,
    output logic      [15:0] TOP_VALUE,
    output logic             AT_BOTTOM,
    output logic             AT_MAX,
    output logic             AT_TOP,
    output logic             COMPARE_A_PWM_ALLOWED,
    output logic             CAPTURE_EVENT
);

    // ****************************************************************
    // mode decode
    // ****************************************************************
    logic        top_is_cmp;
    logic        top_is_cap;
    logic        pwm_mode;
    logic [15:0] top_value;

    always_comb begin
        top_is_cmp = 1'b0;
        top_is_cap = 1'b0;
        pwm_mode   = 1'b1;
        top_value  = COUNT_MAX;
        case (WAVEFORM_MODE_BITS)
            MODE_NORMAL: begin
                pwm_mode = 1'b0;
            end
            MODE_PC_8, MODE_FAST_8: begin
                top_value = TOP_FIXED_8;  // R12
            end
            MODE_PC_9, MODE_FAST_9: begin
                top_value = TOP_FIXED_9;  // R12
            end
            MODE_PC_10, MODE_FAST_10: begin
                top_value = TOP_FIXED_10;  // R12
            end
            MODE_CTC_CMP: begin
                pwm_mode   = 1'b0;
                top_is_cmp = 1'b1;
            end
            MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: begin
                top_is_cmp = 1'b1;
            end
            MODE_PFC_CAP, MODE_PC_CAP, MODE_FAST_CAP: begin
                top_is_cap = 1'b1;
            end
            MODE_CTC_CAP: begin
                pwm_mode   = 1'b0;
                top_is_cap = 1'b1;
            end
            default: begin
                pwm_mode = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0]  latch_r,    latch_nxt;
    logic [7:0]  rdata_r,    rdata_nxt;
    logic [15:0] count_r,    count_nxt;
    logic [15:0] cmp_a_r,    cmp_a_nxt;
    logic [15:0] cmp_b_r,    cmp_b_nxt;
    logic [15:0] cmp_a_buf_r, cmp_a_buf_nxt;
    logic [15:0] cmp_b_buf_r, cmp_b_buf_nxt;
    logic [15:0] capture_r,  capture_nxt;
    logic        capture_hit;
    logic [15:0] top_now;
    logic        at_top;
    logic        wr_low;
    logic        rd_low;

    // compare a as top uses the active value, so a new top lands cleanly
    assign top_now = top_is_cmp ? cmp_a_r : (top_is_cap ? capture_r : top_value);  // R12
    assign at_top  = (count_r == top_now);
    assign wr_low  = BUS_WRITE && !BUS_ADDR[0];  // R01
    assign rd_low  = BUS_READ && !BUS_ADDR[0];   // R01

    always_comb begin
        latch_nxt     = latch_r;
        rdata_nxt     = rdata_r;
        count_nxt     = count_r;
        cmp_a_nxt     = cmp_a_r;
        cmp_b_nxt     = cmp_b_r;
        cmp_a_buf_nxt = cmp_a_buf_r;
        cmp_b_buf_nxt = cmp_b_buf_r;
        capture_nxt   = capture_r;

        // counting first, so a bus write below overrides it
        if (COUNT_CLEAR) begin
            count_nxt = COUNT_BOTTOM;
        end else if (COUNT_STEP) begin
            count_nxt = COUNT_DOWN ? count_r - 16'h0001 : count_r + 16'h0001;
        end

        // pwm modes load compares only at top; elsewhere at once
        if (!pwm_mode || at_top) begin
            cmp_a_nxt = cmp_a_buf_r;  // R13
            cmp_b_nxt = cmp_b_buf_r;
        end

        if (capture_hit && !top_is_cap) begin
            capture_nxt = count_r;  // R14
        end

        if (BUS_WRITE) begin
            if (!wr_low) begin
                latch_nxt = BUS_WDATA;  // R02 R15
            end else begin
                // latch is left as is after a low write
                case (BUS_ADDR)  // R09
                    LOC_COUNT_LOW: begin
                        count_nxt = {latch_r, BUS_WDATA};  // R03 R18
                    end
                    LOC_CMP_A_LOW: begin
                        cmp_a_buf_nxt = {latch_r, BUS_WDATA};  // R03
                        if (!pwm_mode) begin
                            cmp_a_nxt = {latch_r, BUS_WDATA};
                        end
                    end
                    LOC_CMP_B_LOW: begin
                        cmp_b_buf_nxt = {latch_r, BUS_WDATA};  // R03
                        if (!pwm_mode) begin
                            cmp_b_nxt = {latch_r, BUS_WDATA};
                        end
                    end
                    LOC_CAPTURE_LOW: begin
                        if (top_is_cap) begin
                            capture_nxt = {latch_r, BUS_WDATA};  // R17 R03
                        end
                    end
                    default: begin
                        latch_nxt = latch_r;
                    end
                endcase
            end
        end else if (rd_low) begin
            // low reads start a pair; compares leave the latch alone
            case (BUS_ADDR)
                LOC_COUNT_LOW: begin
                    rdata_nxt = count_r[7:0];
                    latch_nxt = count_r[15:8];  // R04
                end
                LOC_CAPTURE_LOW: begin
                    rdata_nxt = capture_r[7:0];
                    latch_nxt = capture_r[15:8];  // R04
                end
                LOC_CMP_A_LOW: begin
                    rdata_nxt = cmp_a_buf_r[7:0];
                end
                default: begin
                    rdata_nxt = cmp_b_buf_r[7:0];
                end
            endcase
        end else if (BUS_READ) begin
            case (BUS_ADDR)
                LOC_CMP_A_HIGH: begin
                    rdata_nxt = cmp_a_buf_r[15:8];  // R05
                end
                LOC_CMP_B_HIGH: begin
                    rdata_nxt = cmp_b_buf_r[15:8];  // R05
                end
                default: begin
                    rdata_nxt = latch_r;  // R15
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            latch_r     <= LATCH_RESET;  // R19
            rdata_r     <= LATCH_RESET;
            count_r     <= WORD_RESET;
            cmp_a_r     <= WORD_RESET;
            cmp_b_r     <= WORD_RESET;
            cmp_a_buf_r <= WORD_RESET;
            cmp_b_buf_r <= WORD_RESET;
            capture_r   <= WORD_RESET;
        end else begin
            latch_r     <= latch_nxt;
            rdata_r     <= rdata_nxt;
            count_r     <= count_nxt;
            cmp_a_r     <= cmp_a_nxt;
            cmp_b_r     <= cmp_b_nxt;
            cmp_a_buf_r <= cmp_a_buf_nxt;
            cmp_b_buf_r <= cmp_b_buf_nxt;
            capture_r   <= capture_nxt;
        end
    end

    // ****************************************************************
    // capture path: synchronise, filter, detect edge
    // ****************************************************************
    logic [1:0]                pin_sync_r,  pin_sync_nxt;
    logic [1:0]                cmp_sync_r,  cmp_sync_nxt;
    logic [FILTER_SAMPLES-1:0] hist_r,      hist_nxt;
    logic                      filt_r,      filt_nxt;
    logic                      filt_prev_r, filt_prev_nxt;
    logic                      hit_r,       hit_nxt;
    logic                      sample;

    // only the second stage of each synchroniser is read
    assign sample      = CAPTURE_FROM_COMPARATOR ? cmp_sync_r[1] : pin_sync_r[1];
    assign capture_hit = hit_r;

    always_comb begin
        pin_sync_nxt  = {pin_sync_r[0], CAPTURE_INPUT_PIN};
        cmp_sync_nxt  = {cmp_sync_r[0], COMPARATOR_OUTPUT};
        hist_nxt      = {hist_r[FILTER_SAMPLES-2:0], sample};
        filt_nxt      = filt_r;
        filt_prev_nxt = filt_r;
        if (!CAPTURE_FILTER_ENABLE) begin
            filt_nxt = sample;
        end else if (&hist_r) begin
            filt_nxt = 1'b1;  // R16
        end else if (~|hist_r) begin
            filt_nxt = 1'b0;  // R16
        end
        // switching the source may look like an edge and capture once
        hit_nxt = (filt_r != filt_prev_r) && (filt_r == CAPTURE_RISING_EDGE);  // R14
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_sync_r  <= 2'h0;
            cmp_sync_r  <= 2'h0;
            hist_r      <= '0;
            filt_r      <= 1'b0;
            filt_prev_r <= 1'b0;
            hit_r       <= 1'b0;
        end else begin
            pin_sync_r  <= pin_sync_nxt;
            cmp_sync_r  <= cmp_sync_nxt;
            hist_r      <= hist_nxt;
            filt_r      <= filt_nxt;
            filt_prev_r <= filt_prev_nxt;
            hit_r       <= hit_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign BUS_RDATA             = rdata_r;
    assign TIMER_COUNT           = count_r;
    assign COMPARE_VALUE_A       = cmp_a_r;
    assign COMPARE_VALUE_B       = cmp_b_r;
    assign CAPTURE_VALUE         = capture_r;
    assign TOP_VALUE             = top_now;
    assign AT_BOTTOM             = (count_r == COUNT_BOTTOM);  // R10
    assign AT_MAX                = (count_r == COUNT_MAX);     // R11
    assign AT_TOP                = at_top;
    assign COMPARE_A_PWM_ALLOWED = !(pwm_mode && top_is_cmp);  // R13
    assign CAPTURE_EVENT         = hit_r && !top_is_cap;       // R14

endmodule

// ---- rtl/timer16_pkg.sv ----
// constants shared by the byte access port of the 16-bit timer
package timer16_pkg;

    // ****************************************************************
    // byte locations, one index per 8-bit register location
    // ****************************************************************
    localparam logic [2:0] LOC_COUNT_LOW     = 3'h0;
    localparam logic [2:0] LOC_COUNT_HIGH    = 3'h1;
    localparam logic [2:0] LOC_CMP_A_LOW     = 3'h2;
    localparam logic [2:0] LOC_CMP_A_HIGH    = 3'h3;
    localparam logic [2:0] LOC_CMP_B_LOW     = 3'h4;
    localparam logic [2:0] LOC_CMP_B_HIGH    = 3'h5;
    localparam logic [2:0] LOC_CAPTURE_LOW   = 3'h6;
    localparam logic [2:0] LOC_CAPTURE_HIGH  = 3'h7;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [7:0]  LATCH_RESET      = 8'h00;
    localparam logic [15:0] WORD_RESET       = 16'h0000;

    // ****************************************************************
    // counter landmarks
    // ****************************************************************
    localparam logic [15:0] COUNT_BOTTOM     = 16'h0000;
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic [15:0] TOP_FIXED_8      = 16'h00ff;
    localparam logic [15:0] TOP_FIXED_9      = 16'h01ff;
    localparam logic [15:0] TOP_FIXED_10     = 16'h03ff;

    // ****************************************************************
    // waveform mode encodings
    // ****************************************************************
    localparam logic [3:0] MODE_NORMAL       = 4'h0;
    localparam logic [3:0] MODE_PC_8         = 4'h1;
    localparam logic [3:0] MODE_PC_9         = 4'h2;
    localparam logic [3:0] MODE_PC_10        = 4'h3;
    localparam logic [3:0] MODE_CTC_CMP      = 4'h4;
    localparam logic [3:0] MODE_FAST_8       = 4'h5;
    localparam logic [3:0] MODE_FAST_9       = 4'h6;
    localparam logic [3:0] MODE_FAST_10      = 4'h7;
    localparam logic [3:0] MODE_PFC_CAP      = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP      = 4'h9;
    localparam logic [3:0] MODE_PC_CAP       = 4'ha;
    localparam logic [3:0] MODE_PC_CMP       = 4'hb;
    localparam logic [3:0] MODE_CTC_CAP      = 4'hc;
    localparam logic [3:0] MODE_RESERVED     = 4'hd;
    localparam logic [3:0] MODE_FAST_CAP     = 4'he;
    localparam logic [3:0] MODE_FAST_CMP     = 4'hf;

    // ****************************************************************
    // capture filter
    // ****************************************************************
    localparam int unsigned FILTER_SAMPLES   = 4;

endpackage

// ---- tb/timer16_props.sv ----
// concurrent checks on the ports of the timer byte access port
`timescale 1ns/1ps

module timer16_props
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    // byte bus
    input wire logic [2:0]  BUS_ADDR,
    input wire logic        BUS_WRITE,
    input wire logic        BUS_READ,
    input wire logic [7:0]  BUS_WDATA,
    input wire logic [7:0]  BUS_RDATA,
    // timer state
    input wire logic [3:0]  WAVEFORM_MODE_BITS,
    input wire logic [15:0] TIMER_COUNT,
    input wire logic [15:0] COMPARE_VALUE_A,
    input wire logic [15:0] CAPTURE_VALUE,
    input wire logic [15:0] TOP_VALUE,
    input wire logic        AT_BOTTOM,
    input wire logic        AT_MAX,
    input wire logic        COMPARE_A_PWM_ALLOWED,
    input wire logic        CAPTURE_EVENT
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    logic [3:0] m;
    logic       rd;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] cmp_hi;
    assign m      = WAVEFORM_MODE_BITS;
    assign rd     = BUS_READ && !BUS_WRITE;
    assign cnt_lo = TIMER_COUNT[7:0];
    assign cnt_hi = TIMER_COUNT[15:8];
    assign cmp_hi = COMPARE_VALUE_A[15:8];
    bottom_flag_a: assert property (AT_BOTTOM == (TIMER_COUNT == COUNT_BOTTOM))
        else $error("bottom flag wrong");
    max_flag_a: assert property (AT_MAX == (TIMER_COUNT == COUNT_MAX))
        else $error("max flag wrong");
    fixed_top_a: assert property (!m[3] && m[1:0] != 2'h0 |-> TOP_VALUE ==
        (m[1:0] == 2'h1 ? TOP_FIXED_8 : m[1:0] == 2'h2 ? TOP_FIXED_9 : TOP_FIXED_10))
        else $error("fixed top wrong");
    capture_top_a: assert property (m[3] && !m[0] |-> TOP_VALUE == CAPTURE_VALUE)
        else $error("capture top wrong");
    pwm_gate_a: assert property (COMPARE_A_PWM_ALLOWED == !(m inside {4'h9, 4'hb, 4'hf}))
        else $error("pwm allow wrong");
    pair_write_a: assert property (BUS_WRITE && BUS_ADDR[0] ##1
        BUS_WRITE && BUS_ADDR == LOC_COUNT_LOW |=>
        TIMER_COUNT == {$past(BUS_WDATA, 2), $past(BUS_WDATA)})
        else $error("paired write wrong");
    low_read_a: assert property (rd && BUS_ADDR == LOC_COUNT_LOW |=> BUS_RDATA == $past(cnt_lo))
        else $error("low read wrong");
    latch_read_a: assert property (rd && BUS_ADDR == LOC_COUNT_LOW ##1
        rd && BUS_ADDR == LOC_COUNT_HIGH |=> BUS_RDATA == $past(cnt_hi, 2))
        else $error("latched high read wrong");
    compare_direct_a: assert property (rd && BUS_ADDR == LOC_CMP_A_HIGH &&
        m inside {4'h0, 4'h4, 4'hc, 4'hd} |=> BUS_RDATA == $past(cmp_hi))
        else $error("compare high read wrong");
    rdata_hold_a: assert property (!rd |=> $stable(BUS_RDATA))
        else $error("read data moved");
    event_pulse_a: assert property (CAPTURE_EVENT |=> !CAPTURE_EVENT)
        else $error("capture pulse too long");
    cover property (CAPTURE_EVENT);
    cover property (AT_MAX);
    cover property (!COMPARE_A_PWM_ALLOWED);
endmodule

bind timer16_byte_access_port timer16_props props_u (
    .CLOCK                 (CLOCK),
    .RESET_N               (RESET_N),
    .BUS_ADDR              (BUS_ADDR),
    .BUS_WRITE             (BUS_WRITE),
    .BUS_READ              (BUS_READ),
    .BUS_WDATA             (BUS_WDATA),
    .BUS_RDATA             (BUS_RDATA),
    .WAVEFORM_MODE_BITS    (WAVEFORM_MODE_BITS),
    .TIMER_COUNT           (TIMER_COUNT),
    .COMPARE_VALUE_A       (COMPARE_VALUE_A),
    .CAPTURE_VALUE         (CAPTURE_VALUE),
    .TOP_VALUE             (TOP_VALUE),
    .AT_BOTTOM             (AT_BOTTOM),
    .AT_MAX                (AT_MAX),
    .COMPARE_A_PWM_ALLOWED (COMPARE_A_PWM_ALLOWED),
    .CAPTURE_EVENT         (CAPTURE_EVENT)
);

// ---- tb/cpu_bus_model.sv ----
// processor model driving the byte bus of the timer port
`timescale 1ns/1ps

module cpu_bus_model
    import timer16_pkg::*;
(
    // clock
    input  wire logic       CLOCK,
    // byte bus
    output logic      [2:0] BUS_ADDR,
    output logic            BUS_WRITE,
    output logic            BUS_READ,
    output logic      [7:0] BUS_WDATA,
    input  wire logic [7:0] BUS_RDATA
);
    initial begin
        BUS_ADDR  = 3'h0;
        BUS_WRITE = 1'b0;
        BUS_READ  = 1'b0;
        BUS_WDATA = 8'h00;
    end
    // one byte cycle: starts just after an edge, ends just after the taking edge
    task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        BUS_WRITE = w;
        BUS_READ  = !w;
        BUS_ADDR  = a;
        BUS_WDATA = w ? d : ~BUS_WDATA;
        @(posedge CLOCK);
        #1;
        q = BUS_RDATA;
    endtask
    // released data toggles so a stale byte never looks valid
    task automatic idle();
        BUS_WRITE = 1'b0;
        BUS_READ  = 1'b0;
        BUS_WDATA = ~BUS_WDATA;
    endtask
    // single caller, so no other access can split a pair
    task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
        logic [7:0] q;
        op(1'b1, lo + 3'h1, v[15:8], q);
        op(1'b1, lo, v[7:0], q);
        idle();
    endtask
    task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
        logic [7:0] q;
        op(1'b0, lo, 8'h00, q);
        v[7:0] = q;
        op(1'b0, lo + 3'h1, 8'h00, q);
        v[15:8] = q;
        idle();
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the timer byte access port
`timescale 1ns/1ps

module tb_top
    import timer16_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, q;
    logic        wr, rd, step, down, clr, filt, from_cmp, rise, pin, comp;
    logic [3:0]  mode;
    logic [15:0] cnt, cmpa, cmpb, cap, top, v;
    logic        at_bot, at_max, at_top, pwm_ok, cap_ev;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    timer16_byte_access_port dut_u (.CLOCK(clock), .RESET_N(reset_n), .BUS_ADDR(addr),
        .BUS_WRITE(wr), .BUS_READ(rd), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
        .WAVEFORM_MODE_BITS(mode), .COUNT_STEP(step), .COUNT_DOWN(down), .COUNT_CLEAR(clr),
        .CAPTURE_FILTER_ENABLE(filt), .CAPTURE_FROM_COMPARATOR(from_cmp),
        .CAPTURE_RISING_EDGE(rise), .CAPTURE_INPUT_PIN(pin), .COMPARATOR_OUTPUT(comp),
        .TIMER_COUNT(cnt), .COMPARE_VALUE_A(cmpa), .COMPARE_VALUE_B(cmpb),
        .CAPTURE_VALUE(cap), .TOP_VALUE(top), .AT_BOTTOM(at_bot), .AT_MAX(at_max),
        .AT_TOP(at_top), .COMPARE_A_PWM_ALLOWED(pwm_ok), .CAPTURE_EVENT(cap_ev));
    cpu_bus_model cpu_u (.CLOCK(clock), .BUS_ADDR(addr), .BUS_WRITE(wr), .BUS_READ(rd),
        .BUS_WDATA(wdata), .BUS_RDATA(rdata));

    always #25 clock = ~clock;
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // counts capture pulses over a window wider than the filtered path
    task automatic wait_cap(input int n, input logic [15:0] val);
        int seen;
        seen = 0;
        repeat (16) begin
            tick(1);
            if (cap_ev === 1'b1) seen++;
        end
        check("capture events", 16'(seen), 16'(n));
        check("capture value", cap, val);
    endtask
    function automatic logic [15:0] exp_top(input logic [3:0] m);
        case (m)
            4'h1, 4'h5: return TOP_FIXED_8;
            4'h2, 4'h6: return TOP_FIXED_9;
            4'h3, 4'h7: return TOP_FIXED_10;
            4'h4, 4'h9, 4'hb, 4'hf: return 16'hab12;
            4'h8, 4'ha, 4'hc, 4'he: return 16'h0000;
            default: return COUNT_MAX;
        endcase
    endfunction

    task automatic t_reset();
        check("count", cnt, WORD_RESET);
        check("bottom", 16'(at_bot), 16'h0001);
        check("top", top, COUNT_MAX);
        cpu_u.op(1'b1, LOC_COUNT_LOW, 8'h34, q);
        cpu_u.idle();
        check("lone low", cnt, 16'h0034);
    endtask
    task automatic t_pairs();
        cpu_u.wr16(LOC_CMP_A_LOW, 16'hab12);
        cpu_u.wr16(LOC_COUNT_LOW, 16'h01ff);
        check("count", cnt, 16'h01ff);
        check("compare a", cmpa, 16'hab12);
        cpu_u.op(1'b0, LOC_COUNT_LOW, 8'h00, q);
        check("count low", 16'(q), 16'h00ff);
        cpu_u.op(1'b0, LOC_CMP_A_HIGH, 8'h00, q);
        check("compare high", 16'(q), 16'h00ab);
        cpu_u.op(1'b0, LOC_COUNT_HIGH, 8'h00, q);
        cpu_u.idle();
        check("count high", 16'(q), 16'h0001);
        cpu_u.rd16(LOC_COUNT_LOW, v);
        check("count read", v, 16'h01ff);
        cpu_u.rd16(LOC_CMP_A_LOW, v);
        check("compare read", v, 16'hab12);
        cpu_u.op(1'b1, LOC_CMP_B_HIGH, 8'h5c, q);
        cpu_u.op(1'b1, LOC_CMP_B_LOW, 8'h01, q);
        cpu_u.op(1'b1, LOC_COUNT_LOW, 8'h02, q);
        check("compare b", cmpb, 16'h5c01);
        check("count reuse", cnt, 16'h5c02);
        cpu_u.op(1'b1, LOC_COUNT_HIGH, 8'h77, q);
        cpu_u.op(1'b0, LOC_CAPTURE_LOW, 8'h00, q);
        cpu_u.op(1'b1, LOC_COUNT_LOW, 8'h03, q);
        cpu_u.idle();
        check("shared latch", cnt, 16'h0003);
    endtask
    task automatic t_counter();
        cpu_u.op(1'b1, LOC_COUNT_HIGH, 8'h12, q);
        step = 1'b1;
        clr = 1'b1;
        cpu_u.op(1'b1, LOC_COUNT_LOW, 8'h34, q);
        step = 1'b0;
        cpu_u.idle();
        check("write wins", cnt, 16'h1234);
        tick(1);
        clr = 1'b0;
        check("cleared", 16'(at_bot), 16'h0001);
        down = 1'b1;
        step = 1'b1;
        tick(1);
        step = 1'b0;
        check("count down", cnt, COUNT_MAX);
        check("max", 16'({at_max, at_bot}), 16'h0002);
        down = 1'b0;
        step = 1'b1;
        tick(1);
        step = 1'b0;
        check("wrap", 16'({at_max, at_bot}), 16'h0001);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 16; m++) begin
            tick(1);
            mode = 4'(m);
            #2;
            check("top", top, exp_top(mode));
            check("pwm allow", 16'(pwm_ok), 16'(!(m == 9 || m == 11 || m == 15)));
        end
        tick(1);
        cpu_u.wr16(LOC_CMP_A_LOW, 16'h0040);
        check("buffered", cmpa, 16'hab12);
        cpu_u.rd16(LOC_CMP_A_LOW, v);
        check("buffer read", v, 16'h0040);
        cpu_u.wr16(LOC_COUNT_LOW, 16'hab11);
        step = 1'b1;
        tick(1);
        step = 1'b0;
        check("at top", 16'(at_top), 16'h0001);
        tick(2);
        check("loaded at top", cmpa, 16'h0040);
        mode = MODE_NORMAL;
    endtask
    task automatic t_capture();
        cpu_u.wr16(LOC_COUNT_LOW, 16'h0777);
        pin = 1'b1;
        wait_cap(1, 16'h0777);
        cpu_u.wr16(LOC_COUNT_LOW, 16'h0888);
        filt = 1'b1;
        pin = 1'b0;
        wait_cap(0, 16'h0777);
        pin = 1'b1;
        tick(2);
        pin = 1'b0;
        wait_cap(0, 16'h0777);
        pin = 1'b1;
        wait_cap(1, 16'h0888);
        filt = 1'b0;
        from_cmp = 1'b1;
        cpu_u.wr16(LOC_COUNT_LOW, 16'h0999);
        comp = 1'b1;
        wait_cap(1, 16'h0999);
        rise = 1'b0;
        cpu_u.wr16(LOC_COUNT_LOW, 16'h0aaa);
        comp = 1'b0;
        wait_cap(1, 16'h0aaa);
        cpu_u.wr16(LOC_CAPTURE_LOW, 16'h0123);
        check("capture refused", cap, 16'h0aaa);
        mode = MODE_CTC_CAP;
        cpu_u.wr16(LOC_CAPTURE_LOW, 16'h0123);
        check("capture written", cap, 16'h0123);
        check("capture top", top, 16'h0123);
        cpu_u.rd16(LOC_CAPTURE_LOW, v);
        check("capture read", v, 16'h0123);
    endtask

    initial begin
        {step, down, clr, filt, from_cmp, pin, comp} = 7'h00;
        rise = 1'b1;
        mode = MODE_NORMAL;
        tick(12);
        reset_n = 1'b1;
        tick(1);
        t_reset();
        t_pairs();
        t_counter();
        t_modes();
        t_capture();
        report_and_stop();
    end
endmodule
